//--- core/tco_timer.sv
// compare override, main counter and system control of the eight channel timer
`timescale 1ns/10ps
`include "tco_defs.svh"
module tco_timer
  import tco_pkg::*;
#(
  parameter bit CHANNEL7_PRESENT = 1'b1
)
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic        WAIT_MODE,
  input  wire logic        FREEZE_MODE,
  input  wire logic        SPECIAL_MODE,
  input  wire logic [7:0]  CHAN_MATCH,
  input  wire logic [7:0]  CHAN_FORCE,
  output logic [7:0]       TIMER_PORT,
  output logic [7:0]       TIMER_PORT_OE,
  output logic [15:0]      COUNT_VALUE,
  output logic             OVERFLOW_EVENT,
  output logic             PRESCALE_TICK,
  output logic             ACCUM_CLK_DIV64,
  output logic             ACCUM_RUN,
  output logic [7:0]       CHAN_FLAG_CLR,
  output logic             OVF_FLAG_CLR,
  output logic             ACCUM_FLAG_CLR
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0]  chan_mode_q;
  logic [7:0]  ovr_mask_q;
  logic [7:0]  ovr_data_q;
  logic [15:0] cnt_q;
  logic [4:0]  sc1_q;
  logic        prec_done_q;
  logic [7:0]  ovt_q;
  logic [15:0] octl_q;
  logic [2:0]  legacy_q;
  logic [7:0]  disc_q;
  logic [7:0]  pps_q;
  logic [7:0]  port_q;

  logic        timer_on;
  logic        wait_stop;
  logic        freeze_stop;
  logic        fast_clear;
  logic        prec_sel;

  assign timer_on    = sc1_q[4];
  assign wait_stop   = sc1_q[3];
  assign freeze_stop = sc1_q[2];
  assign fast_clear  = sc1_q[1];
  assign prec_sel    = sc1_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // bus slave state

  logic        aw_have_q;
  logic        w_have_q;
  logic [5:0]  aw_idx_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q;
  tco_resp_t   bresp_q;
  logic        rvalid_q;
  tco_resp_t   rresp_q;
  logic [31:0] rdata_q;

  logic        wr_fire;
  logic        rd_fire;
  logic        wr_lane0;
  logic [5:0]  rd_idx;
  logic        rd_hit;
  logic [7:0]  rd_byte;
  logic        wr_hit;

  assign S_AXI_AWREADY = !aw_have_q && !bvalid_q;
  assign S_AXI_WREADY  = !w_have_q && !bvalid_q;
  assign S_AXI_ARREADY = !rvalid_q;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = bresp_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RRESP   = rresp_q;
  assign S_AXI_RDATA   = rdata_q;

  assign wr_fire  = aw_have_q && w_have_q;
  assign rd_fire  = S_AXI_ARVALID && !rvalid_q;
  assign wr_lane0 = wr_fire && wstrb_q[0];
  assign rd_idx   = S_AXI_ARADDR[7:2];

  // index decode shared by read and write paths
  function automatic logic idx_mapped(input logic [5:0] idx);
    logic hit;
    hit = 1'b0;
    unique case (idx)
      `TCO_IDX_MODE, `TCO_IDX_OVR_MASK, `TCO_IDX_OVR_DATA, `TCO_IDX_CNT_HI,
      `TCO_IDX_CNT_LO, `TCO_IDX_SC1, `TCO_IDX_OVT, `TCO_IDX_OCTL_HI,
      `TCO_IDX_OCTL_LO, `TCO_IDX_SC2, `TCO_IDX_ACC_HI, `TCO_IDX_ACC_LO,
      `TCO_IDX_DISC, `TCO_IDX_PPS: hit = 1'b1;
      default: hit = (idx >= `TCO_IDX_CHV_FIRST) && (idx <= `TCO_IDX_CHV_LAST);
    endcase
    return hit;
  endfunction

  assign rd_hit = idx_mapped(rd_idx);
  assign wr_hit = idx_mapped(aw_idx_q);

  // write address and data captured in either order
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_idx_q  <= 6'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_q <= 1'b1;
        aw_idx_q  <= S_AXI_AWADDR[7:2];
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_q <= 1'b1;
        wdata_q  <= S_AXI_WDATA;
        wstrb_q  <= S_AXI_WSTRB;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // write response once both halves are in
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      bvalid_q <= 1'b0;
      bresp_q  <= TCO_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? TCO_RESP_OKAY : TCO_RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  // read byte mux, unused bits read zero
  always_comb begin
    rd_byte = 8'h00;
    unique case (rd_idx)
      `TCO_IDX_MODE:     rd_byte = chan_mode_q;
      `TCO_IDX_OVR_MASK: rd_byte = ovr_mask_q;
      `TCO_IDX_OVR_DATA: rd_byte = ovr_data_q;
      `TCO_IDX_CNT_HI:   rd_byte = cnt_q[15:8];
      `TCO_IDX_CNT_LO:   rd_byte = cnt_q[7:0];
      `TCO_IDX_SC1:      rd_byte = {sc1_q, 3'b000};
      `TCO_IDX_OVT:      rd_byte = ovt_q;
      `TCO_IDX_OCTL_HI:  rd_byte = octl_q[15:8];
      `TCO_IDX_OCTL_LO:  rd_byte = octl_q[7:0];
      `TCO_IDX_SC2:      rd_byte = {5'h00, legacy_q};
      `TCO_IDX_DISC:     rd_byte = disc_q;
      `TCO_IDX_PPS:      rd_byte = pps_q;
      default:           rd_byte = 8'h00;
    endcase
  end

  // read answer registered one cycle after address
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      rvalid_q <= 1'b0;
      rresp_q  <= TCO_RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rresp_q  <= rd_hit ? TCO_RESP_OKAY : TCO_RESP_SLVERR;
      rdata_q  <= {24'h00_0000, rd_byte};
    end else if (S_AXI_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  // plain read/write configuration bytes
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      chan_mode_q <= `TCO_RST_BYTE;
      ovr_mask_q  <= `TCO_RST_BYTE;
      ovr_data_q  <= `TCO_RST_BYTE;
      ovt_q       <= `TCO_RST_BYTE;
      octl_q      <= {`TCO_RST_BYTE, `TCO_RST_BYTE};
      legacy_q    <= 3'b000;
      disc_q      <= `TCO_RST_BYTE;
      pps_q       <= `TCO_RST_BYTE;
    end else if (wr_lane0) begin
      unique case (aw_idx_q)
        `TCO_IDX_MODE:     chan_mode_q  <= wdata_q[7:0];
        `TCO_IDX_OVR_MASK: ovr_mask_q   <= wdata_q[7:0];
        `TCO_IDX_OVR_DATA: ovr_data_q   <= wdata_q[7:0];
        `TCO_IDX_OVT:      ovt_q        <= wdata_q[7:0];
        `TCO_IDX_OCTL_HI:  octl_q[15:8] <= wdata_q[7:0];
        `TCO_IDX_OCTL_LO:  octl_q[7:0]  <= wdata_q[7:0];
        `TCO_IDX_SC2:      legacy_q     <= wdata_q[2:0];
        `TCO_IDX_DISC:     disc_q       <= wdata_q[7:0];
        `TCO_IDX_PPS:      pps_q        <= wdata_q[7:0];
        default:           chan_mode_q  <= chan_mode_q;
      endcase
    end
  end

  // system control one, precision select taken only once
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      sc1_q       <= 5'b00000;
      prec_done_q <= 1'b0;
    end else if (wr_lane0 && aw_idx_q == `TCO_IDX_SC1) begin
      sc1_q[4:1]  <= {wdata_q[`TCO_SC1_ON], wdata_q[`TCO_SC1_WAIT],
                      wdata_q[`TCO_SC1_FRZ], wdata_q[`TCO_SC1_FFC]};
      prec_done_q <= 1'b1;
      if (!prec_done_q) begin
        sc1_q[0] <= wdata_q[`TCO_SC1_PREC];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescaler and run conditions

  tco_presc_if pif ();

  logic active;
  logic cnt_run;
  logic ovf_now;

  assign active  = timer_on && !(wait_stop && WAIT_MODE);
  assign cnt_run = active && !(freeze_stop && FREEZE_MODE);

  assign pif.active      = active;
  assign pif.prec_sel    = prec_sel;
  assign pif.legacy_bits = legacy_q;
  assign pif.prec_value  = pps_q;

  tco_prescaler u_presc (
    .clk (SYS_CLK),
    .rst (RST),
    .pif (pif)
  );

  assign ovf_now = cnt_run && pif.tick && (cnt_q == 16'hFFFF);

  ////////////////////////////////////////////////////////////////////////////
  // main counter

  // sixteen bit up count, special mode writes leave prescaler phase alone
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      cnt_q <= `TCO_RST_COUNT;
    end else if (wr_lane0 && SPECIAL_MODE && aw_idx_q == `TCO_IDX_CNT_HI) begin
      cnt_q[15:8] <= wdata_q[7:0];
    end else if (wr_lane0 && SPECIAL_MODE && aw_idx_q == `TCO_IDX_CNT_LO) begin
      cnt_q[7:0] <= wdata_q[7:0];
    end else if (cnt_run && pif.tick) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // registered status outputs
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      OVERFLOW_EVENT  <= 1'b0;
      PRESCALE_TICK   <= 1'b0;
      ACCUM_CLK_DIV64 <= 1'b0;
      ACCUM_RUN       <= 1'b0;
    end else begin
      OVERFLOW_EVENT  <= ovf_now;
      PRESCALE_TICK   <= cnt_run && pif.tick;
      ACCUM_CLK_DIV64 <= pif.div64;
      ACCUM_RUN       <= active;
    end
  end

  assign COUNT_VALUE = cnt_q;

  ////////////////////////////////////////////////////////////////////////////
  // fast flag clearing

  logic       wr_chv;
  logic       rd_chv;
  logic [2:0] wr_ch;
  logic [2:0] rd_ch;

  assign wr_chv = wr_fire && aw_idx_q >= `TCO_IDX_CHV_FIRST && aw_idx_q <= `TCO_IDX_CHV_LAST;
  assign rd_chv = rd_fire && rd_idx >= `TCO_IDX_CHV_FIRST && rd_idx <= `TCO_IDX_CHV_LAST;
  assign wr_ch  = aw_idx_q[3:1];
  assign rd_ch  = rd_idx[3:1];

  // one-cycle clear pulses on qualifying accesses
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      CHAN_FLAG_CLR  <= 8'h00;
      OVF_FLAG_CLR   <= 1'b0;
      ACCUM_FLAG_CLR <= 1'b0;
    end else begin
      for (int i = 0; i < 8; i++) begin
        CHAN_FLAG_CLR[i] <= fast_clear &&
          ((wr_chv && wr_ch == 3'(i) && chan_mode_q[i]) ||
           (rd_chv && rd_ch == 3'(i) && !chan_mode_q[i]));
      end
      OVF_FLAG_CLR <= fast_clear &&
        ((wr_fire && (aw_idx_q == `TCO_IDX_CNT_HI || aw_idx_q == `TCO_IDX_CNT_LO)) ||
         (rd_fire && (rd_idx == `TCO_IDX_CNT_HI || rd_idx == `TCO_IDX_CNT_LO)));
      ACCUM_FLAG_CLR <= fast_clear && CHANNEL7_PRESENT &&
        ((wr_fire && (aw_idx_q == `TCO_IDX_ACC_HI || aw_idx_q == `TCO_IDX_ACC_LO)) ||
         (rd_fire && (rd_idx == `TCO_IDX_ACC_HI || rd_idx == `TCO_IDX_ACC_LO)));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output compare actions per channel

  logic ch7_event;

  assign ch7_event = (ovf_now && ovt_q[7]) || CHAN_MATCH[7];

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_chan
      tco_act_t act;
      logic     drive_ok;

      assign act      = tco_act_t'(octl_q[2*g+1:2*g]);
      assign drive_ok = chan_mode_q[g] && !disc_q[g];

      // override, then overflow toggle, then force, then own match
      always_ff @(posedge SYS_CLK) begin
        if (RST) begin
          port_q[g] <= 1'b0;
        end else if (chan_mode_q[g]) begin
          if (ch7_event && ovr_mask_q[g]) begin
            port_q[g] <= ovr_data_q[g];
          end else if (ovf_now && ovt_q[g]) begin
            port_q[g] <= ~port_q[g];
          end else if (CHAN_FORCE[g]) begin
            port_q[g] <= tco_apply(act, port_q[g]);
          end else if (CHAN_MATCH[g]) begin
            port_q[g] <= tco_apply(act, port_q[g]);
          end
        end
      end

      assign TIMER_PORT_OE[g] = drive_ok && (ovr_mask_q[g] || act != TCO_ACT_NONE || ovt_q[g]);
    end
  endgenerate

  assign TIMER_PORT = port_q;

endmodule

//--- core/tco_defs.svh
// register indices, field positions, reset values and timing counts for the compare override timer
`ifndef TCO_DEFS_SVH
`define TCO_DEFS_SVH

// register indices: byte address is four times the index
`define TCO_IDX_MODE      6'h00
`define TCO_IDX_OVR_MASK  6'h02
`define TCO_IDX_OVR_DATA  6'h03
`define TCO_IDX_CNT_HI    6'h04
`define TCO_IDX_CNT_LO    6'h05
`define TCO_IDX_SC1       6'h06
`define TCO_IDX_OVT       6'h07
`define TCO_IDX_OCTL_HI   6'h08
`define TCO_IDX_OCTL_LO   6'h09
`define TCO_IDX_SC2       6'h0D
`define TCO_IDX_CHV_FIRST 6'h10
`define TCO_IDX_CHV_LAST  6'h1F
`define TCO_IDX_ACC_HI    6'h22
`define TCO_IDX_ACC_LO    6'h23
`define TCO_IDX_DISC      6'h2C
`define TCO_IDX_PPS       6'h2E

// system control one field positions
`define TCO_SC1_ON   7
`define TCO_SC1_WAIT 6
`define TCO_SC1_FRZ  5
`define TCO_SC1_FFC  4
`define TCO_SC1_PREC 3

// reset values
`define TCO_RST_BYTE  8'h00
`define TCO_RST_COUNT 16'h0000

// fixed accumulator clock division
`define TCO_ACC_DIV   7'h40

`endif

//--- core/tco_pkg.sv
// types and output action decode for the compare override timer
package tco_pkg;

  typedef enum logic [1:0] {
    TCO_ACT_NONE   = 2'b00,
    TCO_ACT_TOGGLE = 2'b01,
    TCO_ACT_LOW    = 2'b10,
    TCO_ACT_HIGH   = 2'b11
  } tco_act_t;

  typedef enum logic [1:0] {
    TCO_RESP_OKAY   = 2'b00,
    TCO_RESP_SLVERR = 2'b10
  } tco_resp_t;

  // next pin level for a mode/level pair
  function automatic logic tco_apply(input tco_act_t act, input logic cur);
    logic nxt;
    nxt = cur;
    unique case (act)
      TCO_ACT_NONE:   nxt = cur;
      TCO_ACT_TOGGLE: nxt = ~cur;
      TCO_ACT_LOW:    nxt = 1'b0;
      TCO_ACT_HIGH:   nxt = 1'b1;
    endcase
    return nxt;
  endfunction

endpackage

//--- core/tco_presc_if.sv
// carrier between the timer core and its prescaler
`timescale 1ns/10ps
interface tco_presc_if;
  logic       active;
  logic       prec_sel;
  logic [2:0] legacy_bits;
  logic [7:0] prec_value;
  logic       tick;
  logic       div64;

  modport ctl   (output active, output prec_sel, output legacy_bits, output prec_value,
                 input tick, input div64);
  modport presc (input active, input prec_sel, input legacy_bits, input prec_value,
                 output tick, output div64);
endinterface

//--- core/tco_prescaler.sv
// counter prescaler and fixed divide-by-64 accumulator clock
`timescale 1ns/10ps
`include "tco_defs.svh"
module tco_prescaler
  import tco_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rst,
  tco_presc_if.presc  pif
);

  logic [7:0] div_q;
  logic [7:0] limit;
  logic [5:0] acc_q;

  // division limit: legacy power of two or full precision byte
  always_comb begin
    if (pif.prec_sel) begin
      limit = pif.prec_value;
    end else begin
      limit = 8'((8'h01 << pif.legacy_bits) - 8'h01);
    end
  end

  // prescale divider, cleared to zero while the timer is inactive
  always_ff @(posedge clk) begin
    if (rst || !pif.active) begin
      div_q <= 8'h00;
    end else if (div_q >= limit) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  assign pif.tick = pif.active && (div_q >= limit);

  // divide-by-64 for the pulse accumulator, absent when inactive
  always_ff @(posedge clk) begin
    if (rst || !pif.active) begin
      acc_q <= 6'h00;
    end else begin
      acc_q <= acc_q + 6'h01;
    end
  end

  assign pif.div64 = pif.active && (acc_q == 6'(`TCO_ACC_DIV - 7'h01));

endmodule

//--- testbench/tco_timer_monitor.sv
// port-level assertions for the compare override timer
`timescale 1ns/10ps
module tco_timer_monitor (
  input wire logic        SYS_CLK,
  input wire logic        RST,
  input wire logic [7:0]  S_AXI_AWADDR,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic [7:0]  S_AXI_ARADDR,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic [15:0] COUNT_VALUE,
  input wire logic        OVERFLOW_EVENT,
  input wire logic        ACCUM_CLK_DIV64,
  input wire logic        ACCUM_RUN,
  input wire logic        OVF_FLAG_CLR
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);

  // counter moves by one upward step unless a write lands
  a_count_step: assert property ($changed(COUNT_VALUE) && !$rose(S_AXI_BVALID) && !$past(RST)
    |-> COUNT_VALUE == $past(COUNT_VALUE) + 16'h0001) else $error("counter stepped wrongly");
  // overflow pulse follows an all-ones count
  a_ovf_cause: assert property (OVERFLOW_EVENT
    |-> $past(COUNT_VALUE) == 16'hFFFF || $past(COUNT_VALUE, 2) == 16'hFFFF) else $error("overflow without wrap");
  a_ovf_pulse: assert property (OVERFLOW_EVENT |=> !OVERFLOW_EVENT)
    else $error("overflow pulse too long");
  // no divide-by-64 clock while the timer is idle
  a_accum_off: assert property (!ACCUM_RUN && !$past(ACCUM_RUN) |-> !ACCUM_CLK_DIV64)
    else $error("accumulator clock while inactive");
  // fast overflow clear only after a counter access
  a_fclr_cause: assert property (OVF_FLAG_CLR
    |-> ($past(S_AXI_ARADDR) >> 3) == 8'h02 || ($past(S_AXI_AWADDR) >> 3) == 8'h02)
    else $error("stray overflow clear");
  // bus answer timing and blocking
  a_wr_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
    |-> ##2 S_AXI_BVALID) else $error("write answer late");
  a_aw_block: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken during response");
  a_rd_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  a_rd_block: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken during response");
  a_rd_upper: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000)
    else $error("read upper bits set");
endmodule

bind tco_timer tco_timer_monitor u_mon (
  .SYS_CLK(SYS_CLK), .RST(RST), .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
  .COUNT_VALUE(COUNT_VALUE), .OVERFLOW_EVENT(OVERFLOW_EVENT), .ACCUM_CLK_DIV64(ACCUM_CLK_DIV64),
  .ACCUM_RUN(ACCUM_RUN), .OVF_FLAG_CLR(OVF_FLAG_CLR)
);

//--- testbench/tco_timer_tb_top.sv
// self-checking bench for the compare override timer
`timescale 1ns/10ps
`include "tco_defs.svh"
module tco_timer_tb_top;
  logic        clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, wait_md, frz_md, spec_md, ovf, acc_run;
  logic        tick, ovf_clr, acc_clr;
  logic [7:0]  awaddr, araddr, match, port, oe, frc, chan_clr;
  logic [9:0]  clr_v;
  logic [31:0] wdata, rdata, rd_v;
  logic [1:0]  bresp, rresp, resp;
  logic [15:0] cnt, c0;
  int          error_cnt, n_tests, n;

  tco_timer dut (
    .SYS_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .WAIT_MODE(wait_md), .FREEZE_MODE(frz_md),
    .SPECIAL_MODE(spec_md), .CHAN_MATCH(match), .CHAN_FORCE(frc), .TIMER_PORT(port), .TIMER_PORT_OE(oe),
    .COUNT_VALUE(cnt), .OVERFLOW_EVENT(ovf), .PRESCALE_TICK(tick), .ACCUM_CLK_DIV64(), .ACCUM_RUN(acc_run),
    .CHAN_FLAG_CLR(chan_clr), .OVF_FLAG_CLR(ovf_clr), .ACCUM_FLAG_CLR(acc_clr)
  );

  // clock generation
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic hang();
    error_cnt++;
    close_out();
  endtask

  // bus write: address and data offered together, held until taken
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic a, w, b;
    @(posedge clk);
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    b = 1'b0;
    for (int k = 0; k < 40 && !b; k++) begin
      @(negedge clk);
      a = awvalid & awready;
      w = wvalid & wready;
      b = bvalid;
      resp = bresp;
      clr_v = {acc_clr, ovf_clr, chan_clr};
      @(posedge clk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
    end
    if (!b) hang();
  endtask

  // bus read: address held until taken, data taken with rvalid
  task automatic rd(input logic [5:0] idx);
    logic a, r;
    @(posedge clk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    r = 1'b0;
    for (int k = 0; k < 40 && !r; k++) begin
      @(negedge clk);
      a = arvalid & arready;
      r = rvalid;
      rd_v = rdata;
      resp = rresp;
      clr_v = {acc_clr, ovf_clr, chan_clr};
      @(posedge clk);
      if (a) arvalid <= 1'b0;
      if (r) rready <= 1'b0;
    end
    if (!r) hang();
  endtask

  // one-cycle compare and force pulses, then let the port settle
  task automatic pulse(input logic [7:0] m, input logic [7:0] f);
    @(posedge clk);
    match <= m;
    frc   <= f;
    @(posedge clk);
    match <= 8'h00;
    frc   <= 8'h00;
    repeat (3) @(negedge clk);
  endtask

  task automatic stall_chk(input string nm, input logic [15:0] exp);
    repeat (20) @(negedge clk);
    chk(nm, cnt, exp);
  endtask

  // main sequence
  initial begin
    {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h01 << 5;
    {wait_md, frz_md, spec_md, awaddr, araddr, match, frc, wdata} = '0;
    error_cnt = 0;
    n_tests = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(`TCO_IDX_SC1);
    chk("control reset", rd_v, 32'h00000000);
    rd(6'h3F);
    chk("unmapped read", resp, tco_pkg::TCO_RESP_SLVERR);
    wr(6'h3F, 8'hA5);
    chk("unmapped write", resp, tco_pkg::TCO_RESP_SLVERR);
    wr(`TCO_IDX_SC2, 8'h02);
    chk("write okay", resp, tco_pkg::TCO_RESP_OKAY);
    wr(`TCO_IDX_SC1, 8'hB0);
    @(negedge clk);
    c0 = cnt;
    n = 0;
    // forty cycles at divide-by-four hold exactly ten ticks
    repeat (40) begin
      @(negedge clk);
      n += tick;
    end
    chk("legacy rate", cnt, c0 + 16'h000A);
    chk("tick count", n, 32'h0000000A);
    wr(`TCO_IDX_SC1, 8'hB8);
    rd(`TCO_IDX_SC1);
    chk("precision lock", rd_v, 32'h000000B0);
    wr(`TCO_IDX_SC1, 8'h30);
    @(negedge clk);
    c0 = cnt;
    stall_chk("timer off", c0);
    wr(`TCO_IDX_CNT_HI, 8'h12);
    stall_chk("normal write", c0);
    @(posedge clk);
    spec_md <= 1'b1;
    wr(`TCO_IDX_CNT_HI, 8'hFF);
    wr(`TCO_IDX_CNT_LO, 8'hFC);
    @(negedge clk);
    chk("special write", cnt, 16'hFFFC);
    rd(`TCO_IDX_CNT_LO);
    chk("counter low", rd_v, 32'h000000FC);
    chk("counter access clear", clr_v, 10'h100);
    wr(`TCO_IDX_MODE, 8'h01);
    wr(`TCO_IDX_OVT, 8'h01);
    @(posedge clk);
    frz_md <= 1'b1;
    wr(`TCO_IDX_SC1, 8'hB0);
    stall_chk("freeze stop", 16'hFFFC);
    chk("freeze accum run", acc_run, 32'h00000001);
    @(posedge clk);
    frz_md <= 1'b0;
    for (n = 0; n < 100 && ovf !== 1'b1; n++) @(negedge clk);
    if (n == 100) hang();
    chk("wrap", cnt[15:2], 32'h00000000);
    chk("overflow toggle", port, 32'h00000001);
    chk("toggle enable", oe, 32'h00000001);
    @(posedge clk);
    wait_md <= 1'b1;
    wr(`TCO_IDX_SC1, 8'hF0);
    @(negedge clk);
    c0 = cnt;
    stall_chk("wait stop", c0);
    chk("accum run", acc_run, 32'h00000000);
    @(posedge clk);
    wait_md <= 1'b0;
    wr(`TCO_IDX_SC1, 8'hB0);
    wr(`TCO_IDX_OCTL_LO, 8'h02);
    wr(`TCO_IDX_OVR_MASK, 8'h0F);
    wr(`TCO_IDX_OVR_DATA, 8'h37);
    wr(`TCO_IDX_MODE, 8'hFD);
    wr(`TCO_IDX_DISC, 8'h04);
    chk("output enable", oe, 32'h00000009);
    pulse(8'h81, 8'h00);
    chk("override", port, 32'h00000005);
    wr(`TCO_IDX_OCTL_LO, 8'hE1);
    wr(`TCO_IDX_OVR_MASK, 8'h00);
    pulse(8'h7F, 8'h00);
    chk("compare actions", port, 32'h00000008);
    pulse(8'h00, 8'h01);
    chk("forced action", port, 32'h00000009);
    wr(`TCO_IDX_CHV_FIRST, 8'h00);
    chk("compare write clear", clr_v, 10'h001);
    rd(6'h12);
    chk("capture read clear", clr_v, 10'h002);
    rd(`TCO_IDX_CHV_FIRST);
    chk("compare read kept", clr_v, 10'h000);
    rd(`TCO_IDX_ACC_HI);
    chk("accum access clear", clr_v, 10'h200);
    // second reset re-arms the one-shot precision select
    @(posedge clk);
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(`TCO_IDX_SC1);
    chk("second reset", rd_v, 32'h00000000);
    chk("reset port", port, 32'h00000000);
    chk("reset count", cnt, 16'h0000);
    wr(`TCO_IDX_PPS, 8'h04);
    wr(`TCO_IDX_SC1, 8'h88);
    @(negedge clk);
    c0 = cnt;
    repeat (50) @(negedge clk);
    chk("precision rate", cnt, c0 + 16'h000A);
    wr(`TCO_IDX_SC1, 8'h80);
    rd(`TCO_IDX_SC1);
    chk("precision kept", rd_v, 32'h00000088);
    rd(`TCO_IDX_CNT_HI);
    chk("no fast clear", clr_v, 10'h000);
    close_out();
  end

  // run limit
  initial begin
    #5000000;
    hang();
  end
endmodule
